// ---- design/hbs_sequencer.v ----
// Function
// - A switch-on command first magnetizes the motor before any brake action.
// - When the magnetizing interval expires the brake-open command is asserted.
// - After brake-open the motor is held at zero speed for the brake opening time.
// - When the opening time ends the speed hold is released and the motor ramps to setpoint.
// - A normal or fast stop decelerates the motor toward zero with the brake still open.
// - While decelerating, setpoint below the threshold starts the standstill monitor timer.
// - While decelerating, actual speed below the threshold starts the pulse-cancel timer.
// - Brake-close is asserted as soon as the first of those two timers expires.
// - After brake-close on a normal or fast stop the motor stays powered at standstill.
// - After the brake closing time the motor power is switched off.
// - A coast stop closes the brake at once regardless of speed, skipping the closing time.
// - A nonzero resistor braking power setting below HBS_POWER_LOW lengthens ramp-down; it resets to zero.
// - The coast stop source may be a digital input carrying resistor overtemperature.
`timescale 1ns/1ps
`include "hbs_map.vh"
module hbs_sequencer #(
   parameter TICK_DIV = `HBS_TICK_NS / `HBS_CLK_NS
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [15:0] speed_setpoint,
   input  wire [15:0] actual_speed,
   input  wire        overtemp_in,
   output reg         motor_power,
   output reg         brake_open,
   output reg         speed_hold,
   output reg         ramp_down,
   output reg         ramp_extend
);
   // one-hot states
   localparam S_IDLE  = 6'b000001;
   localparam S_MAG   = 6'b000010;
   localparam S_OPEN  = 6'b000100;
   localparam S_RUN   = 6'b001000;
   localparam S_DECEL = 6'b010000;
   localparam S_CLOSE = 6'b100000;

   reg [`HBS_CTRL_W-1:0] ctrl_reg;
   reg [15:0]            mag_reg;
   reg [15:0]            open_reg;
   reg [15:0]            close_reg;
   reg [15:0]            thresh_reg;
   reg [15:0]            monitor_reg;
   reg [15:0]            pcancel_reg;
   reg [15:0]            power_reg;
   reg [5:0]             state_reg;
   reg [5:0]             state_next;
   reg                   ot_meta_reg;
   reg                   ot_sync_reg;
   reg                   mon_started_reg;
   reg                   pc_started_reg;

   wire tick;
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr  = wb_req && wb_we_i;

   // each set byte lane enable on the low half writes its byte of the 16-bit settings
   function [15:0] lane16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0]  sel;
      begin
         lane16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   // coast stop from software or, when selected, the overtemperature input
   wire coast = ctrl_reg[`HBS_CTRL_CSTOP] ||
                (ctrl_reg[`HBS_CTRL_CSRC] && ot_sync_reg);
   wire stop  = ctrl_reg[`HBS_CTRL_NSTOP] || ctrl_reg[`HBS_CTRL_FSTOP];
   wire on    = ctrl_reg[`HBS_CTRL_ON] && !stop;

   // threshold comparisons used while decelerating
   wire set_low = speed_setpoint < thresh_reg;
   wire act_low = actual_speed < thresh_reg;

   wire mag_done;
   wire open_done;
   wire close_done;
   wire mon_done;
   wire pc_done;

   // entry and threshold strobes for timer loads
   wire enter_mag   = state_reg[0] && on && !coast;
   wire enter_open  = state_reg[1] && mag_done && !coast;
   wire enter_close = state_reg[4] && (mon_done || pc_done) && !coast;
   wire mon_load    = state_reg[4] && set_low && !mon_started_reg;
   wire pc_load     = state_reg[4] && act_low && !pc_started_reg;

   // overtemperature pin synchroniser
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ot_meta_reg <= 1'b0;
         ot_sync_reg <= 1'b0;
      end else begin
         ot_meta_reg <= overtemp_in;
         ot_sync_reg <= ot_meta_reg;
      end
   end

   hbs_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   // interval counters leaving the state drops run and so cancels them
   hbs_timer #(.W(16)) u_mag (
      .clk (clk), .rst (rst), .load (enter_mag), .run (state_reg[1] && !coast),
      .tick (tick), .value (mag_reg), .done (mag_done)
   );
   hbs_timer #(.W(16)) u_open (
      .clk (clk), .rst (rst), .load (enter_open), .run (state_reg[2] && !coast),
      .tick (tick), .value (open_reg), .done (open_done)
   );
   hbs_timer #(.W(16)) u_close (
      .clk (clk), .rst (rst), .load (enter_close), .run (state_reg[5] && !coast),
      .tick (tick), .value (close_reg), .done (close_done)
   );
   hbs_timer #(.W(16)) u_mon (
      .clk (clk), .rst (rst), .load (mon_load), .run (state_reg[4] && !coast),
      .tick (tick), .value (monitor_reg), .done (mon_done)
   );
   hbs_timer #(.W(16)) u_pc (
      .clk (clk), .rst (rst), .load (pc_load), .run (state_reg[4] && !coast),
      .tick (tick), .value (pcancel_reg), .done (pc_done)
   );

   // sequencer next state
   always @* begin
      state_next = state_reg;
      if (coast) begin
         state_next = S_IDLE;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (on) state_next = S_MAG;
            end
            S_MAG: begin
               if (stop || !ctrl_reg[`HBS_CTRL_ON]) state_next = S_IDLE;
               else if (mag_done) state_next = S_OPEN;
            end
            S_OPEN: begin
               if (stop) state_next = S_DECEL;
               else if (open_done) state_next = S_RUN;
            end
            S_RUN: begin
               if (stop || !ctrl_reg[`HBS_CTRL_ON]) state_next = S_DECEL;
            end
            S_DECEL: begin
               if (mon_done || pc_done) state_next = S_CLOSE;
            end
            S_CLOSE: begin
               if (close_done) state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
         endcase
      end
   end

   // state, timer start flags and registered motor outputs
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg       <= S_IDLE;
         mon_started_reg <= 1'b0;
         pc_started_reg  <= 1'b0;
         motor_power     <= 1'b0;
         brake_open      <= 1'b0;
         speed_hold      <= 1'b0;
         ramp_down       <= 1'b0;
         ramp_extend     <= 1'b0;
      end else begin
         state_reg       <= state_next;
         mon_started_reg <= state_next[4] && (mon_started_reg || mon_load);
         pc_started_reg  <= state_next[4] && (pc_started_reg || pc_load);
         // powered through magnetizing, open, run, decel and closing time
         motor_power     <= !state_next[0];
         // open from end of magnetizing until the close command
         brake_open      <= state_next[2] || state_next[3] || state_next[4];
         // hold zero speed while magnetizing and opening, and at standstill while closing
         speed_hold      <= state_next[1] || state_next[2] || state_next[5];
         ramp_down       <= state_next[4];
         ramp_extend     <= state_next[4] && (power_reg != 16'h0000) &&
                            (power_reg < `HBS_POWER_LOW);
      end
   end

   // wishbone slave: one-cycle ack, writes at the acked edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
         ctrl_reg    <= {`HBS_CTRL_W{1'b0}};
         mag_reg     <= `HBS_RST_MAG;
         open_reg    <= `HBS_RST_OPEN;
         close_reg   <= `HBS_RST_CLOSE;
         thresh_reg  <= `HBS_RST_THRESH;
         monitor_reg <= `HBS_RST_MONITOR;
         pcancel_reg <= `HBS_RST_PCANCEL;
         power_reg   <= `HBS_RST_POWER;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_wr) begin
            case (wb_adr_i)
               `HBS_ADR_CTRL:    if (wb_sel_i[0]) ctrl_reg <= wb_dat_i[`HBS_CTRL_W-1:0];
               `HBS_ADR_MAG:     mag_reg     <= lane16(mag_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_OPEN:    open_reg    <= lane16(open_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_CLOSE:   close_reg   <= lane16(close_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_THRESH:  thresh_reg  <= lane16(thresh_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_MONITOR: monitor_reg <= lane16(monitor_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_PCANCEL: pcancel_reg <= lane16(pcancel_reg, wb_dat_i, wb_sel_i);
               `HBS_ADR_POWER:   power_reg   <= lane16(power_reg, wb_dat_i, wb_sel_i);
               default: ;
            endcase
         end
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `HBS_ADR_CTRL:    wb_dat_o <= {27'h0000000, ctrl_reg};
               `HBS_ADR_MAG:     wb_dat_o <= {16'h0000, mag_reg};
               `HBS_ADR_OPEN:    wb_dat_o <= {16'h0000, open_reg};
               `HBS_ADR_CLOSE:   wb_dat_o <= {16'h0000, close_reg};
               `HBS_ADR_THRESH:  wb_dat_o <= {16'h0000, thresh_reg};
               `HBS_ADR_MONITOR: wb_dat_o <= {16'h0000, monitor_reg};
               `HBS_ADR_PCANCEL: wb_dat_o <= {16'h0000, pcancel_reg};
               `HBS_ADR_POWER:   wb_dat_o <= {16'h0000, power_reg};
               `HBS_ADR_STATUS:  wb_dat_o <= {20'h00000, ot_sync_reg, ramp_extend, ramp_down,
                                              speed_hold, brake_open, motor_power, state_reg};
               `HBS_ADR_SPEED:   wb_dat_o <= {actual_speed, speed_setpoint};
               default:          wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // hbs_sequencer

// ---- design/hbs_map.vh ----
`ifndef HBS_MAP_VH
`define HBS_MAP_VH
// register byte offsets
`define HBS_ADR_CTRL       8'h00
`define HBS_ADR_MAG        8'h04
`define HBS_ADR_OPEN       8'h08
`define HBS_ADR_CLOSE      8'h0c
`define HBS_ADR_THRESH     8'h10
`define HBS_ADR_MONITOR    8'h14
`define HBS_ADR_PCANCEL    8'h18
`define HBS_ADR_POWER      8'h1c
`define HBS_ADR_STATUS     8'h20
`define HBS_ADR_SPEED      8'h24
// control register fields
`define HBS_CTRL_ON        0
`define HBS_CTRL_NSTOP     1
`define HBS_CTRL_FSTOP     2
`define HBS_CTRL_CSTOP     3
`define HBS_CTRL_CSRC      4
`define HBS_CTRL_W         5
// reset values (intervals in ticks, speed in rpm, power in kW)
`define HBS_RST_MAG        16'h0000
`define HBS_RST_OPEN       16'h0064
`define HBS_RST_CLOSE      16'h0064
`define HBS_RST_THRESH     16'h0014
`define HBS_RST_MONITOR    16'hffff
`define HBS_RST_PCANCEL    16'h000a
`define HBS_RST_POWER      16'h0000
// timebase: 1 ms tick at 200 MHz
`define HBS_TICK_NS        1000000
`define HBS_CLK_NS         5
// ramp lengthening below this power (kW)
`define HBS_POWER_LOW      16'h0002
`endif

// ---- design/hbs_tick.v ----
`timescale 1ns/1ps
`include "hbs_map.vh"
// one-cycle timebase enable from a free divider
module hbs_tick #(
   parameter DIV = `HBS_TICK_NS / `HBS_CLK_NS
) (
   input  wire clk,
   input  wire rst,
   output reg  tick
);
   reg [23:0] cnt_reg;

   // count down and pulse on wrap
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 24'h000000;
         tick    <= 1'b0;
      end else if (cnt_reg == 24'h000000) begin
         cnt_reg <= DIV[23:0] - 24'h000001;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg - 24'h000001;
         tick    <= 1'b0;
      end
   end
endmodule // hbs_tick

// ---- design/hbs_timer.v ----
`timescale 1ns/1ps
// down-counter: load, count on tick, level done when zero
module hbs_timer #(
   parameter W = 16
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         load,
   input  wire         run,
   input  wire         tick,
   input  wire [W-1:0] value,
   output wire         done
);
   reg [W-1:0] cnt_reg;
   reg         arm_reg;

   assign done = arm_reg && (cnt_reg == {W{1'b0}});

   // load wins, else step down while running
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= {W{1'b0}};
         arm_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= value;
         arm_reg <= 1'b1;
      end else if (!run) begin
         arm_reg <= 1'b0;
      end else if (tick && cnt_reg != {W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // hbs_timer

// ---- verification/hbs_seq_asserts.sv ----
`timescale 1ns/1ps
// port-level checks of the bus handshake and the brake sequence
module hbs_seq_asserts #(
   parameter TICK_DIV = 4
) (
   input wire clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire motor_power,
   input wire brake_open,
   input wire speed_hold,
   input wire ramp_down,
   input wire ramp_extend
);
   default clocking dcb @(posedge clk); endclocking
   default disable iff (rst);
   // a fresh request, and the first step of a start
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_power_up;
      $rose(motor_power);
   endsequence
   AST_ACK_REQ: assert property (s_req |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_START: assert property (s_power_up |-> speed_hold && !brake_open)
      else $error("brake acted before magnetizing");
   AST_OPEN: assert property ($rose(brake_open) |-> speed_hold && motor_power)
      else $error("brake opened without powered hold");
   AST_RUN: assert property ($fell(speed_hold) && motor_power |-> brake_open)
      else $error("hold released with brake shut");
   AST_DECEL: assert property (ramp_down |-> brake_open && motor_power)
      else $error("brake shut while ramping down");
   AST_CLOSE: assert property ($fell(brake_open) && motor_power |-> speed_hold)
      else $error("motor not held at brake close");
   AST_OFF: assert property ($fell(motor_power) |-> !brake_open && !speed_hold)
      else $error("motor off with brake open");
   AST_EXT: assert property (ramp_extend |-> ramp_down)
      else $error("ramp extended outside ramp-down");
endmodule // hbs_seq_asserts
bind hbs_sequencer hbs_seq_asserts #(.TICK_DIV(TICK_DIV)) hbs_seq_asserts_inst (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .motor_power(motor_power), .brake_open(brake_open), .speed_hold(speed_hold),
   .ramp_down(ramp_down), .ramp_extend(ramp_extend));

// ---- verification/hbs_motor_model.sv ----
`timescale 1ns/1ps
// motor shaft: speed moves one rpm a cycle after the drive outputs
module hbs_motor_model (
   input  wire        clk,
   input  wire        rst,
   input  wire        motor_power,
   input  wire        speed_hold,
   input  wire        ramp_down,
   input  wire [15:0] speed_setpoint,
   output reg  [15:0] actual_speed
);
   // unpowered, held or braking it slows, otherwise it tracks the setpoint
   always @(posedge clk or posedge rst) begin
      if (rst)
         actual_speed <= 16'h0000;
      else if (!motor_power || speed_hold || ramp_down || actual_speed > speed_setpoint)
         actual_speed <= (actual_speed != 16'h0000) ? actual_speed - 16'h0001 : 16'h0000;
      else if (actual_speed < speed_setpoint)
         actual_speed <= actual_speed + 16'h0001;
   end
endmodule // hbs_motor_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "hbs_map.vh"
module tb_top;
   localparam int TD = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [15:0] setp = 16'h0000;
   logic        hot = 1'b0;
   wire  [31:0] wb_dat_o;
   wire  [15:0] act;
   wire         ack, pwr, brk, hold, down, ext;
   wire  [4:0]  outs = {ext, down, hold, brk, pwr};
   int          failures = 0;
   int          n_checks = 0;
   int          t;

   // clock
   always #2.5 clk = ~clk;

   // design and motor
   hbs_sequencer #(.TICK_DIV(TD)) hbs_sequencer_inst (.clk(clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .speed_setpoint(setp),
      .actual_speed(act), .overtemp_in(hot), .motor_power(pwr), .brake_open(brk),
      .speed_hold(hold), .ramp_down(down), .ramp_extend(ext));
   hbs_motor_model hbs_motor_model_inst (.clk(clk), .rst(rst), .motor_power(pwr),
      .speed_hold(hold), .ramp_down(down), .speed_setpoint(setp), .actual_speed(act));

   task summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task chk_rng(input int got, input int lo, input int hi, input string m);
      n_checks++;
      if (got < lo || got > hi) begin
         failures++;
         $display("wrong value at %0t: %s took %0d", $time, m, got);
      end
   endtask

   // one classic cycle, held until ack is sampled high at a rising edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: bus timeout", $time);
         summarize();
      end
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // wait for one output to reach a level, cycles in t
   task wait_bit(input int i, input logic v);
      t = 0;
      while (outs[i] !== v && t < 2000) begin
         @(posedge clk);
         #1;
         t++;
      end
      if (t >= 2000) begin
         failures++;
         $display("wrong value at %0t: output wait timeout", $time);
         summarize();
      end
   endtask

   task t_regs;
      logic [7:0]  a[8] = '{`HBS_ADR_MAG, `HBS_ADR_OPEN, `HBS_ADR_CLOSE, `HBS_ADR_THRESH,
                            `HBS_ADR_MONITOR, `HBS_ADR_PCANCEL, `HBS_ADR_POWER, 8'h30};
      logic [15:0] e[8] = '{`HBS_RST_MAG, `HBS_RST_OPEN, `HBS_RST_CLOSE, `HBS_RST_THRESH,
                            `HBS_RST_MONITOR, `HBS_RST_PCANCEL, `HBS_RST_POWER, 16'h0000};
      chk(outs, 5'h00, "reset idle");
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, a[i], 32'h0);
         chk(rdat, {16'h0000, e[i]}, "reset value");
      end
   endtask

   task t_start;
      xfer(1'b1, `HBS_ADR_MAG, 32'h3);
      xfer(1'b1, `HBS_ADR_OPEN, 32'h2);
      xfer(1'b1, `HBS_ADR_CLOSE, 32'h2);
      setp <= 16'h0028;
      xfer(1'b1, `HBS_ADR_CTRL, 32'h1);
      wait_bit(0, 1'b1);
      chk({brk, hold}, 2'b01, "magnetize first");
      wait_bit(1, 1'b1);
      chk_rng(t, 2 * TD + 1, 3 * TD, "magnetize time");
      chk(hold, 1'b1, "hold while opening");
      wait_bit(2, 1'b0);
      chk_rng(t, TD + 2, 2 * TD + 1, "opening time");
   endtask

   task t_stop(input logic [31:0] c, input logic [15:0] sp, input int lo, input int hi,
               input logic x);
      @(posedge clk);
      setp <= sp;
      xfer(1'b1, `HBS_ADR_CTRL, c);
      wait_bit(3, 1'b1);
      chk({pwr, brk}, 2'b11, "decel brake open");
      wait_bit(4, x);
      chk_rng(t, 0, 2, "ramp extension");
      wait_bit(1, 1'b0);
      chk_rng(t, lo, hi, "close delay");
      chk({pwr, hold}, 2'b11, "held at close");
      wait_bit(0, 1'b0);
      chk_rng(t, TD + 2, 2 * TD + 1, "closing time");
      xfer(1'b1, `HBS_ADR_CTRL, 32'h0);
   endtask

   task t_coast;
      xfer(1'b1, `HBS_ADR_CTRL, 32'h1);
      wait_bit(1, 1'b1);
      xfer(1'b1, `HBS_ADR_CTRL, 32'h9);
      wait_bit(0, 1'b0);
      chk_rng(t, 0, 2, "coast close");
      chk(outs, 5'h00, "coast idle");
      xfer(1'b1, `HBS_ADR_CTRL, 32'h11);
      wait_bit(0, 1'b1);
      @(posedge clk);
      hot <= 1'b1;
      wait_bit(0, 1'b0);
      chk_rng(t, 1, 6, "pin coast");
      chk(outs, 5'h00, "pin coast idle");
      xfer(1'b0, `HBS_ADR_STATUS, 32'h0);
      chk(rdat, 32'h00000801, "status word");
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_start();
      t_stop(32'h3, 16'h0028, 9 * TD + 2, 10 * TD + 1, 1'b0);
      xfer(1'b1, `HBS_ADR_MONITOR, 32'h2);
      xfer(1'b1, `HBS_ADR_PCANCEL, 32'hc8);
      xfer(1'b1, `HBS_ADR_POWER, 32'h1);
      xfer(1'b0, `HBS_ADR_PCANCEL, 32'h0);
      chk(rdat, 32'h000000c8, "settings readback");
      t_start();
      t_stop(32'h5, 16'h0000, TD + 2, 2 * TD + 1, 1'b1);
      t_coast();
      summarize();
   end
endmodule // tb_top
